// File: hdl/fsr_pkg.sv
// Purpose: Shared constants and types for the flash status register bank.
// Assumes: One 100 MHz clock, synchronous active-high reset.
// Notes:   Bit positions, reset values and masks live here only.
package fsr_pkg;

  localparam int unsigned CLK_MHZ      = 100;
  localparam int unsigned WRSR_TIME_NS = 50;
  localparam int unsigned WRSR_CYC     = (WRSR_TIME_NS * CLK_MHZ + 999) / 1000;

  localparam logic [1:0] SEL_ONE   = 2'h0;
  localparam logic [1:0] SEL_TWO   = 2'h1;
  localparam logic [1:0] SEL_THREE = 2'h2;

  localparam int unsigned S3_PIN_FUNC = 7;
  localparam int unsigned S3_DRV_HI   = 6;
  localparam int unsigned S3_DRV_LO   = 5;
  localparam int unsigned S3_SCHEME   = 2;
  localparam int unsigned S2_PAUSED   = 7;
  localparam int unsigned S2_INVERT   = 6;
  localparam int unsigned S2_OTP_HI   = 5;
  localparam int unsigned S2_OTP_LO   = 2;
  localparam int unsigned S2_QE       = 1;
  localparam int unsigned S2_LOCK_HI  = 0;
  localparam int unsigned S1_LOCK_LO  = 7;
  localparam int unsigned S1_UNIT     = 6;
  localparam int unsigned S1_TB       = 5;
  localparam int unsigned S1_RANGE_HI = 4;
  localparam int unsigned S1_RANGE_LO = 2;
  localparam int unsigned S1_WEL      = 1;
  localparam int unsigned S1_BUSY     = 0;

  localparam logic [7:0] S1_RST   = 8'h00;
  localparam logic [7:0] S2_RST   = 8'h00;
  localparam logic [7:0] S3_RST   = 8'h40;
  localparam logic [7:0] S1_WMASK = 8'hfc;
  localparam logic [7:0] S2_WMASK = 8'h43;
  localparam logic [7:0] S2_OTPM  = 8'h3c;
  localparam logic [7:0] S3_WMASK = 8'he4;

  localparam int unsigned ADDR_W        = 24;
  localparam logic [24:0] ARRAY_SPAN    = 25'h1000000;
  localparam logic [4:0]  SEC_EXP_BASE  = 5'h0b;
  localparam logic [4:0]  BLK_EXP_BASE  = 5'h11;
  localparam logic [2:0]  SEC_RANGE_CAP = 3'h4;

  typedef enum logic [1:0] {
    FSR_IDLE   = 2'b00,
    FSR_WRSR   = 2'b01,
    FSR_ARRAY  = 2'b10,
    FSR_PAUSED = 2'b11
  } fsr_state_e;

  typedef struct packed {
    logic              wren;
    logic              wrdi;
    logic              wrsr;
    logic [1:0]        sel;
    logic [7:0]        data;
    logic              prog;
    logic              erase;
    logic              suspend;
    logic              resume;
    logic [ADDR_W-1:0] addr;
  } fsr_cmd_s;

  typedef struct packed {
    logic       scheme;
    logic       invert;
    logic       unit;
    logic       tb;
    logic [2:0] range;
  } fsr_prot_s;

endpackage

// File: hdl/fsr_protect_map.sv
// Purpose: Decides whether an array address falls in the protected region.
// Assumes: Configuration bits come from the status register bank.
// Notes:   Purely combinational; the caller uses the result unregistered to gate array operations.
`timescale 1ns/10ps
module fsr_protect_map (
  input  wire fsr_pkg::fsr_prot_s      cfg_i,
  input  wire logic [fsr_pkg::ADDR_W-1:0] addr_i,
  input  wire logic                    blk_lock_i,
  output logic                         hit_o
);

  logic [2:0]  sec_r;
  logic [4:0]  expo;
  logic [24:0] span;
  logic [24:0] addr_x;
  logic        in_rng;

  always_comb begin
    sec_r  = (cfg_i.range > fsr_pkg::SEC_RANGE_CAP) ? fsr_pkg::SEC_RANGE_CAP : cfg_i.range;
    // Sectors grow from 4KB, blocks from 256KB.
    expo   = cfg_i.unit ? (fsr_pkg::SEC_EXP_BASE + {2'h0, sec_r}) :
                          (fsr_pkg::BLK_EXP_BASE + {2'h0, cfg_i.range});
    span   = 25'h1 << expo;
    addr_x = {1'b0, addr_i};
    in_rng = 1'b0;
    if (cfg_i.range != 3'h0) begin
      if (cfg_i.tb) begin
        in_rng = addr_x < span;
      end else begin
        in_rng = addr_x >= (fsr_pkg::ARRAY_SPAN - span);
      end
    end
    if (cfg_i.scheme) begin
      hit_o = blk_lock_i;
    end else begin
      hit_o = in_rng ^ cfg_i.invert;
    end
  end

endmodule

// File: hdl/fsr_status_bank.sv
// Purpose: Three 8-bit status and configuration registers of a serial flash.
// Assumes: Instructions arrive decoded, one per cycle, synchronous to clk_i.
// Notes:   rst_i is the power-up reset; all bits return to their defaults.
`timescale 1ns/10ps
module fsr_status_bank (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire fsr_pkg::fsr_cmd_s cmd_i,
  input  wire logic             op_done_i,
  input  wire logic             blk_lock_i,
  input  wire logic             protect_pin_n_i,
  input  wire logic             pause_pin_n_i,
  input  wire logic [1:0]       rd_sel_i,
  output logic [7:0]            rd_data_o,
  output logic                  op_start_o,
  output logic                  op_erase_o,
  output logic                  op_reject_o,
  output logic                  engine_hold_o,
  output logic                  pause_active_o,
  output logic                  hw_reset_o,
  output logic                  quad_mode_o,
  output logic [1:0]            drive_strength_o,
  output logic [3:0]            otp_lock_o,
  output logic                  prot_scheme_o
);

  fsr_pkg::fsr_state_e state_ff;
  fsr_pkg::fsr_state_e nxt_state;
  fsr_pkg::fsr_prot_s  prot_cfg;

  logic [7:0] sr1_ff;
  logic [7:0] sr2_ff;
  logic [7:0] sr3_ff;
  logic [7:0] pend_data_ff;
  logic [1:0] pend_sel_ff;
  logic [3:0] wcnt_ff;
  logic       wel_ff;
  logic       erase_ff;
  logic       busy;
  logic       paused;
  logic       lock_hw;
  logic       lock_all;
  logic       arr_req;
  logic       prot_hit;
  logic       wrsr_ok;
  logic       arr_ok;
  logic       commit;
  logic       quad;
  logic [7:0] rd_one;
  logic [7:0] rd_two;
  logic [7:0] rd_three;

  // Protection configuration handed to the address map.
  assign prot_cfg.scheme = sr3_ff[fsr_pkg::S3_SCHEME];
  assign prot_cfg.invert = sr2_ff[fsr_pkg::S2_INVERT];
  assign prot_cfg.unit   = sr1_ff[fsr_pkg::S1_UNIT];
  assign prot_cfg.tb     = sr1_ff[fsr_pkg::S1_TB];
  assign prot_cfg.range  = sr1_ff[fsr_pkg::S1_RANGE_HI:fsr_pkg::S1_RANGE_LO];

  fsr_protect_map u_map (
    .cfg_i      (prot_cfg),
    .addr_i     (cmd_i.addr),
    .blk_lock_i (blk_lock_i),
    .hit_o      (prot_hit)
  );

  assign quad   = sr2_ff[fsr_pkg::S2_QE];
  assign busy   = (state_ff == fsr_pkg::FSR_WRSR) || (state_ff == fsr_pkg::FSR_ARRAY);
  assign paused = (state_ff == fsr_pkg::FSR_PAUSED);

  // The protect pin only counts while it is not a quad data line.
  assign lock_hw  = !quad && !sr2_ff[fsr_pkg::S2_LOCK_HI] &&
                    sr1_ff[fsr_pkg::S1_LOCK_LO] && !protect_pin_n_i;
  assign lock_all = lock_hw || sr2_ff[fsr_pkg::S2_LOCK_HI];

  assign arr_req = cmd_i.prog || cmd_i.erase;
  assign wrsr_ok = cmd_i.wrsr && (state_ff == fsr_pkg::FSR_IDLE) && wel_ff && !lock_all;
  assign arr_ok  = arr_req && (state_ff == fsr_pkg::FSR_IDLE) && wel_ff && !prot_hit;
  assign commit  = (state_ff == fsr_pkg::FSR_WRSR) && (wcnt_ff == 4'h0);

  // Sequencer for status writes and array operations.
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      fsr_pkg::FSR_IDLE: begin
        if (wrsr_ok) begin
          nxt_state = fsr_pkg::FSR_WRSR;
        end else if (arr_ok) begin
          nxt_state = fsr_pkg::FSR_ARRAY;
        end
      end
      fsr_pkg::FSR_WRSR: begin
        if (commit) begin
          nxt_state = fsr_pkg::FSR_IDLE;
        end
      end
      fsr_pkg::FSR_ARRAY: begin
        if (op_done_i) begin
          nxt_state = fsr_pkg::FSR_IDLE;
        end else if (cmd_i.suspend && erase_ff) begin
          nxt_state = fsr_pkg::FSR_PAUSED;
        end
      end
      fsr_pkg::FSR_PAUSED: begin
        if (cmd_i.resume) begin
          nxt_state = fsr_pkg::FSR_ARRAY;
        end
      end
      default: begin
        nxt_state = fsr_pkg::FSR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= fsr_pkg::FSR_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Status write busy time.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wcnt_ff <= 4'h0;
    end else if (wrsr_ok) begin
      wcnt_ff <= 4'(fsr_pkg::WRSR_CYC - 1);
    end else if (wcnt_ff != 4'h0) begin
      wcnt_ff <= wcnt_ff - 4'h1;
    end
  end

  // Write data held until the status write completes.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_data_ff <= 8'h00;
      pend_sel_ff  <= fsr_pkg::SEL_ONE;
    end else if (wrsr_ok) begin
      pend_data_ff <= cmd_i.data;
      pend_sel_ff  <= cmd_i.sel;
    end
  end

  // Write enable latch; a new enable wins over a same-cycle clear.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wel_ff <= 1'b0;
    end else if (cmd_i.wren) begin
      wel_ff <= 1'b1;
    end else if (cmd_i.wrdi || wrsr_ok || arr_ok) begin
      wel_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      erase_ff <= 1'b0;
    end else if (arr_ok) begin
      erase_ff <= cmd_i.erase;
    end
  end

  // Register commit; read-only and reserved bits are masked out.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sr1_ff <= fsr_pkg::S1_RST;
      sr2_ff <= fsr_pkg::S2_RST;
      sr3_ff <= fsr_pkg::S3_RST;
    end else if (commit) begin
      case (pend_sel_ff)
        fsr_pkg::SEL_ONE: begin
          sr1_ff <= pend_data_ff & fsr_pkg::S1_WMASK;
        end
        fsr_pkg::SEL_TWO: begin
          sr2_ff <= (pend_data_ff & fsr_pkg::S2_WMASK) |
                    ((sr2_ff | pend_data_ff) & fsr_pkg::S2_OTPM);
        end
        fsr_pkg::SEL_THREE: begin
          sr3_ff <= pend_data_ff & fsr_pkg::S3_WMASK;
        end
        default: begin
          sr1_ff <= sr1_ff;
        end
      endcase
    end
  end

  // Read views with live flags merged in.
  always_comb begin
    rd_one   = sr1_ff;
    rd_one[fsr_pkg::S1_WEL]  = wel_ff;
    rd_one[fsr_pkg::S1_BUSY] = busy;
    rd_two   = sr2_ff;
    rd_two[fsr_pkg::S2_PAUSED] = paused;
    rd_three = sr3_ff & fsr_pkg::S3_WMASK;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_data_o <= 8'h00;
    end else begin
      case (rd_sel_i)
        fsr_pkg::SEL_ONE:   rd_data_o <= rd_one;
        fsr_pkg::SEL_TWO:   rd_data_o <= rd_two;
        fsr_pkg::SEL_THREE: rd_data_o <= rd_three;
        default:            rd_data_o <= 8'h00;
      endcase
    end
  end

  // Engine handshake and refusal pulses.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      op_start_o    <= 1'b0;
      op_erase_o    <= 1'b0;
      op_reject_o   <= 1'b0;
      engine_hold_o <= 1'b0;
    end else begin
      op_start_o    <= arr_ok;
      op_erase_o    <= arr_ok && cmd_i.erase;
      op_reject_o   <= (arr_req && !arr_ok) || (cmd_i.wrsr && !wrsr_ok);
      engine_hold_o <= (nxt_state == fsr_pkg::FSR_PAUSED);
    end
  end

  // Pin functions and configuration outputs.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pause_active_o   <= 1'b0;
      hw_reset_o       <= 1'b0;
      quad_mode_o      <= 1'b0;
      drive_strength_o <= fsr_pkg::S3_RST[fsr_pkg::S3_DRV_HI:fsr_pkg::S3_DRV_LO];
      otp_lock_o       <= 4'h0;
      prot_scheme_o    <= 1'b0;
    end else begin
      pause_active_o   <= !quad && !sr3_ff[fsr_pkg::S3_PIN_FUNC] && !pause_pin_n_i;
      hw_reset_o       <= !quad && sr3_ff[fsr_pkg::S3_PIN_FUNC] && !pause_pin_n_i;
      quad_mode_o      <= quad;
      drive_strength_o <= sr3_ff[fsr_pkg::S3_DRV_HI:fsr_pkg::S3_DRV_LO];
      otp_lock_o       <= sr2_ff[fsr_pkg::S2_OTP_HI:fsr_pkg::S2_OTP_LO];
      prot_scheme_o    <= sr3_ff[fsr_pkg::S3_SCHEME];
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_wrsr_taken;
    cmd_i.wrsr && wrsr_ok;
  endsequence

  sequence s_wrsr_busy;
    busy [*5] ##1 !busy;
  endsequence

  a_pin_reset_fn: assert property (
    (!quad && sr3_ff[fsr_pkg::S3_PIN_FUNC] && !pause_pin_n_i) |=> hw_reset_o && !pause_active_o)
    else $error("reset pin function not applied");

  a_quad_pin_off: assert property (
    quad |=> !hw_reset_o && !pause_active_o)
    else $error("pin function active in quad mode");

  a_drive_commit: assert property (
    (commit && pend_sel_ff == fsr_pkg::SEL_THREE) |=> ##1
      drive_strength_o == $past(pend_data_ff[fsr_pkg::S3_DRV_HI:fsr_pkg::S3_DRV_LO], 2))
    else $error("drive strength not updated");

  a_paused_flag: assert property (
    (state_ff == fsr_pkg::FSR_ARRAY && !op_done_i && cmd_i.suspend && erase_ff)
      |=> paused && !busy && engine_hold_o)
    else $error("suspend did not set paused flag");

  a_resume_clears: assert property (
    (paused && cmd_i.resume) |=> !paused && busy)
    else $error("resume did not clear paused flag");

  a_otp_sticky: assert property (
    !$past(rst_i) |-> (sr2_ff[fsr_pkg::S2_OTP_HI:fsr_pkg::S2_OTP_LO] &
      $past(sr2_ff[fsr_pkg::S2_OTP_HI:fsr_pkg::S2_OTP_LO])) ==
      $past(sr2_ff[fsr_pkg::S2_OTP_HI:fsr_pkg::S2_OTP_LO]))
    else $error("one-time lock bit cleared");

  a_wel_gate: assert property (
    (arr_req && !wel_ff) |=> op_reject_o && !op_start_o)
    else $error("operation started without write enable");

  a_wrsr_busy: assert property (
    s_wrsr_taken |=> s_wrsr_busy)
    else $error("status write busy time wrong");

  a_prot_block: assert property (
    (arr_req && prot_hit) |=> !op_start_o && (state_ff != fsr_pkg::FSR_ARRAY || $past(busy)))
    else $error("protected region operation started");

  a_hw_lock: assert property (
    (cmd_i.wrsr && lock_all) |=> op_reject_o && state_ff != fsr_pkg::FSR_WRSR)
    else $error("status write accepted while locked");

  a_ro_ignored: assert property (
    commit |=> !sr1_ff[fsr_pkg::S1_WEL] && !sr1_ff[fsr_pkg::S1_BUSY] &&
      !sr2_ff[fsr_pkg::S2_PAUSED])
    else $error("read-only bit stored from write data");

  a_disable_clears_wel: assert property (
    (cmd_i.wrdi && !cmd_i.wren) |=> !wel_ff)
    else $error("write disable did not clear the latch");

  a_block_scheme: assert property (
    prot_cfg.scheme |-> prot_hit == blk_lock_i)
    else $error("block lock scheme not applied");

  a_range_zero: assert property (
    (!prot_cfg.scheme && prot_cfg.range == 3'h0) |-> prot_hit == prot_cfg.invert)
    else $error("empty range protection wrong");

  a_soft_unlock: assert property (
    (!sr2_ff[fsr_pkg::S2_LOCK_HI] && !sr1_ff[fsr_pkg::S1_LOCK_LO]) |-> !lock_all)
    else $error("status register locked in software mode");

endmodule

// File: testbench/fsr_host_model.sv
// Purpose: Host side of the status bank: issues decoded instructions and reads registers.
// Assumes: Requests change just after a rising edge and are taken at the next one.
// Notes:   Released fields show the inverse of the last value, strobes drop to zero.
`timescale 1ns/10ps
module fsr_host_model (
  input  wire logic         clk_i,
  input  wire logic         op_start_i,
  input  wire logic         op_reject_i,
  input  wire logic [7:0]   rd_data_i,
  output fsr_pkg::fsr_cmd_s cmd_o,
  output logic [1:0]        rd_sel_o
);
  initial begin
    cmd_o    = '0;
    rd_sel_o = 2'h3;
  end

  // Holds one instruction for one cycle, then samples the answer pulses.
  task automatic issue(input fsr_pkg::fsr_cmd_s c, output logic st, output logic rj);
    fsr_pkg::fsr_cmd_s idle;
    idle      = '0;
    idle.sel  = ~c.sel;
    idle.data = ~c.data;
    idle.addr = ~c.addr;
    @(posedge clk_i);
    cmd_o <= c;
    @(posedge clk_i);
    cmd_o <= idle;
    #1;
    st = op_start_i;
    rj = op_reject_i;
  endtask

  // Selects a register and takes the registered read data one cycle later.
  task automatic read(input logic [1:0] sel, output logic [7:0] d);
    @(posedge clk_i);
    rd_sel_o <= sel;
    @(posedge clk_i);
    #1;
    d = rd_data_i;
  endtask
endmodule

// File: testbench/test_flash_status_register_bank.sv
// Purpose: Self-checking test of the flash status register bank.
// Assumes: The host model drives instructions; the bench drives pins and engine done.
// Notes:   Expected values follow the bit map and reset values of the three registers.
`timescale 1ns/10ps
module test_flash_status_register_bank;
  typedef struct packed {
    logic [1:0]  sel;
    logic [7:0]  data;
    logic        lock;
    logic [23:0] addr;
    logic        ok;
  } fsr_case_s;

  logic              clk_i           = 1'b0;
  logic              rst_i           = 1'b1;
  logic              op_done_i       = 1'b0;
  logic              blk_lock_i      = 1'b0;
  logic              protect_pin_n_i = 1'b1;
  logic              pause_pin_n_i   = 1'b1;
  fsr_pkg::fsr_cmd_s cmd;
  logic [1:0]        rd_sel;
  logic [7:0]        rd_data;
  logic              op_start;
  logic              op_erase;
  logic              op_reject;
  logic              hold;
  logic              pause_act;
  logic              hw_rst;
  logic              quad;
  logic [1:0]        drv;
  logic [3:0]        otp;
  logic              scheme;
  logic              st;
  logic              rj;
  logic [7:0]        d;
  int                fails           = 0;
  int                n_checks        = 0;
  fsr_case_s         tbl [10];

  always #5 clk_i = ~clk_i;

  fsr_status_bank fsr_status_bank_i (
    .clk_i(clk_i), .rst_i(rst_i), .cmd_i(cmd), .op_done_i(op_done_i),
    .blk_lock_i(blk_lock_i), .protect_pin_n_i(protect_pin_n_i),
    .pause_pin_n_i(pause_pin_n_i), .rd_sel_i(rd_sel), .rd_data_o(rd_data),
    .op_start_o(op_start), .op_erase_o(op_erase), .op_reject_o(op_reject),
    .engine_hold_o(hold), .pause_active_o(pause_act), .hw_reset_o(hw_rst),
    .quad_mode_o(quad), .drive_strength_o(drv), .otp_lock_o(otp), .prot_scheme_o(scheme)
  );

  fsr_host_model fsr_host_model_i (
    .clk_i(clk_i), .op_start_i(op_start), .op_reject_i(op_reject),
    .rd_data_i(rd_data), .cmd_o(cmd), .rd_sel_o(rd_sel)
  );

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Kinds: 0 wren, 1 wrsr, 2 prog, 3 erase, 4 suspend, 5 resume, 6 write disable.
  task automatic op(input int k, input logic [1:0] s, input logic [7:0] v, input logic [23:0] a);
    fsr_pkg::fsr_cmd_s c;
    c      = '0;
    c.sel  = s;
    c.data = v;
    c.addr = a;
    case (k)
      0: c.wren = 1'b1;
      1: c.wrsr = 1'b1;
      2: c.prog = 1'b1;
      3: c.erase = 1'b1;
      4: c.suspend = 1'b1;
      5: c.resume = 1'b1;
      default: c.wrdi = 1'b1;
    endcase
    fsr_host_model_i.issue(c, st, rj);
  endtask

  task automatic rd(input logic [1:0] s, input logic [7:0] exp);
    fsr_host_model_i.read(s, d);
    chk_reg(d, exp);
  endtask

  task automatic wait_idle();
    for (int n = 0; n < 50; n++) begin
      fsr_host_model_i.read(fsr_pkg::SEL_ONE, d);
      if (d[0] === 1'b0) return;
    end
    fails++;
    results();
  endtask

  task automatic wrsr(input logic [1:0] s, input logic [7:0] v, input logic exp_rj);
    op(0, s, v, 24'h0);
    op(1, s, v, 24'h0);
    chk_bit(rj, exp_rj);
    if (exp_rj === 1'b0) wait_idle();
  endtask

  task automatic done_pulse();
    @(posedge clk_i);
    op_done_i <= 1'b1;
    @(posedge clk_i);
    op_done_i <= 1'b0;
    wait_idle();
  endtask

  initial begin
    tbl[0] = '{fsr_pkg::SEL_ONE, 8'h9c, 1'b0, 24'h000000, 1'b0};
    tbl[1] = '{fsr_pkg::SEL_ONE, 8'h84, 1'b0, 24'hffffff, 1'b0};
    tbl[2] = '{fsr_pkg::SEL_ONE, 8'h84, 1'b0, 24'h000000, 1'b1};
    tbl[3] = '{fsr_pkg::SEL_ONE, 8'ha4, 1'b0, 24'h000000, 1'b0};
    tbl[4] = '{fsr_pkg::SEL_ONE, 8'hc4, 1'b0, 24'hfff000, 1'b0};
    tbl[5] = '{fsr_pkg::SEL_ONE, 8'hc4, 1'b0, 24'hff0000, 1'b1};
    tbl[6] = '{fsr_pkg::SEL_ONE, 8'h80, 1'b0, 24'h000000, 1'b1};
    tbl[7] = '{fsr_pkg::SEL_ONE, 8'h9c, 1'b0, 24'h000000, 1'b0};
    tbl[8] = '{fsr_pkg::SEL_THREE, 8'h04, 1'b1, 24'h000000, 1'b0};
    tbl[9] = '{fsr_pkg::SEL_THREE, 8'h04, 1'b0, 24'h000000, 1'b1};
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(2'h0, 8'h00);
    rd(2'h1, 8'h00);
    rd(2'h2, 8'h40);
    rd(2'h3, 8'h00);
    chk_reg({6'h0, drv}, 8'h02);
    $display("test reset values done");
    op(1, fsr_pkg::SEL_ONE, 8'hff, 24'h0);
    chk_bit(rj, 1'b1);
    op(0, 2'h0, 8'h00, 24'h0);
    rd(fsr_pkg::SEL_ONE, 8'h02);
    op(6, 2'h0, 8'h00, 24'h0);
    rd(fsr_pkg::SEL_ONE, 8'h00);
    op(2, 2'h0, 8'h00, 24'h0);
    chk_reg({6'h0, st, rj}, 8'h01);
    op(0, 2'h0, 8'h00, 24'h0);
    op(1, fsr_pkg::SEL_ONE, 8'hff, 24'h0);
    rd(fsr_pkg::SEL_ONE, 8'h01);
    wait_idle();
    rd(fsr_pkg::SEL_ONE, 8'hfc);
    $display("test write status one done");
    @(posedge clk_i);
    pause_pin_n_i <= 1'b0;
    wrsr(fsr_pkg::SEL_THREE, 8'hff, 1'b0);
    rd(fsr_pkg::SEL_THREE, 8'he4);
    chk_reg({3'h0, pause_act, hw_rst, drv, scheme}, 8'h0f);
    wrsr(fsr_pkg::SEL_THREE, 8'h00, 1'b0);
    chk_reg({3'h0, pause_act, hw_rst, drv, scheme}, 8'h10);
    $display("test status three done");
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_i);
      blk_lock_i <= tbl[i].lock;
      wrsr(tbl[i].sel, tbl[i].data, 1'b0);
      op(0, 2'h0, 8'h00, 24'h0);
      op(2, 2'h0, 8'h00, tbl[i].addr);
      chk_bit(st, tbl[i].ok);
      if (tbl[i].ok === 1'b1) done_pulse();
    end
    $display("test protection map done");
    @(posedge clk_i);
    protect_pin_n_i <= 1'b0;
    wrsr(fsr_pkg::SEL_ONE, 8'h00, 1'b1);
    @(posedge clk_i);
    protect_pin_n_i <= 1'b1;
    $display("test pin lock done");
    op(0, 2'h0, 8'h00, 24'h0);
    op(3, 2'h0, 8'h00, 24'h0);
    chk_reg({6'h0, st, op_erase}, 8'h03);
    op(4, 2'h0, 8'h00, 24'h0);
    chk_bit(hold, 1'b1);
    rd(fsr_pkg::SEL_TWO, 8'h80);
    rd(fsr_pkg::SEL_ONE, 8'h9c);
    op(5, 2'h0, 8'h00, 24'h0);
    chk_bit(hold, 1'b0);
    rd(fsr_pkg::SEL_TWO, 8'h00);
    rd(fsr_pkg::SEL_ONE, 8'h9d);
    done_pulse();
    $display("test erase suspend done");
    wrsr(fsr_pkg::SEL_TWO, 8'hff, 1'b0);
    rd(fsr_pkg::SEL_TWO, 8'h7f);
    chk_reg({2'h0, pause_act, quad, otp}, 8'h1f);
    wrsr(fsr_pkg::SEL_ONE, 8'h00, 1'b1);
    $display("test status two done");
    results();
  end
endmodule
